// ===== rtl/dcc_pkg.sv
// Operation
// - Transition from previous and current clock-enable samples
// - Power-down entry and exit carry NOP or deselect
// - Self refresh held while enable low; exit NOP
// - Self refresh entry: REFRESH with falling enable, idle
// - After self refresh: NOPs, reads after 200
// - Falling enable: active or precharge power down
// - No power down during busy operations
// - Hold each enable level three registered edges
// - Power down skips refresh; keep it short
// - Enable stays high during driver calibration
// - No termination in self refresh; defined otherwise
// - Steady-high enable: only legal table commands
// - Chip select high ignores command inputs
// - NOP command leaves operations unaffected
// - Mode load: bank selects register, address value
// - Activate opens row until bank precharged
// - Read burst; address bit ten auto-precharges
// - Write burst; address bit ten auto-precharges
// - Additive latency delays internal column registration
// - Masked-high write bytes are left unchanged
// - Commands decoded from strobes at rising edge
package dcc_pkg;
	localparam int DCC_BA_W = 3;
	localparam int DCC_A_W = 14;
	localparam int DCC_COL_W = 10;
	localparam int DCC_DW = 16;
	localparam int DCC_DM_W = DCC_DW / 8;
	localparam int DCC_BANKS = 8;
	localparam int DCC_AP_BIT = 10;
	// Command code is {ras_n, cas_n, we_n} with chip select low
	localparam logic [2:0] DCC_CMD_MRS = 3'h0;
	localparam logic [2:0] DCC_CMD_REF = 3'h1;
	localparam logic [2:0] DCC_CMD_PRE = 3'h2;
	localparam logic [2:0] DCC_CMD_ACT = 3'h3;
	localparam logic [2:0] DCC_CMD_WR = 3'h4;
	localparam logic [2:0] DCC_CMD_RD = 3'h5;
	localparam logic [2:0] DCC_CMD_NOP = 3'h7;
	// Mode register selections and fields
	localparam logic [2:0] DCC_MR_MAIN = 3'h0;
	localparam logic [2:0] DCC_MR_EXT1 = 3'h1;
	localparam int DCC_AL_LSB = 3;
	localparam int DCC_AL_W = 3;
	localparam int DCC_ODT_BIT_LO = 2;
	localparam int DCC_ODT_BIT_HI = 6;
	// Timing in clocks, and the width of the delay counters
	localparam int DCC_CKE_MIN = 3;
	localparam int DCC_XSRD_CLK = 200;
	localparam int DCC_CNT_W = 8;
	// Controller register map (byte offsets) and fields
	localparam logic [7:0] DCC_REG_CMD = 8'h00;
	localparam logic [7:0] DCC_REG_CTRL = 8'h04;
	localparam logic [7:0] DCC_REG_WDATA = 8'h08;
	localparam logic [7:0] DCC_REG_STAT = 8'h0C;
	localparam logic [7:0] DCC_REG_RDATA = 8'h10;
	localparam int DCC_F_CODE = 0;
	localparam int DCC_F_BA = 4;
	localparam int DCC_F_ADDR = 8;
	localparam int DCC_F_CKE = 0;
	localparam int DCC_F_ODT = 1;
	localparam int DCC_F_ERR = 3;
	typedef enum logic [1:0] {DCC_ST_ON, DCC_ST_APD, DCC_ST_PPD, DCC_ST_SREF} dcc_pwr_e;
	typedef struct packed {
		logic v;
		logic wr;
		logic ap;
		logic [DCC_BA_W-1:0] ba;
		logic [DCC_COL_W-1:0] col;
	} dcc_col_s;
endpackage

// ===== rtl/dcc_if.sv
`timescale 1ns/100ps
// Command, address and data wires between controller and memory
interface dcc_if;
	import dcc_pkg::*;
	logic cke;
	logic cs_n;
	logic ras_n;
	logic cas_n;
	logic we_n;
	logic [DCC_BA_W-1:0] ba;
	logic [DCC_A_W-1:0] addr;
	logic odt;
	logic [DCC_DM_W-1:0] dm;
	logic [DCC_DW-1:0] wdata;
	logic [DCC_DW-1:0] rdata;
	logic rvalid;
	modport ctl (output cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt, dm, wdata,
		input rdata, rvalid);
	modport mem (input cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt, dm, wdata,
		output rdata, rvalid);
endinterface

// ===== rtl/dcc_mem.sv
`timescale 1ns/100ps
// Memory end: clock-enable state, command execution, bursts
module dcc_mem import dcc_pkg::*; #(
	parameter int BL = 4,
	parameter int MEM_AW = 6,
	parameter int MAX_AL = 6
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	dcc_if.mem link,
	output logic [1:0] pwr_state,
	output logic [DCC_BANKS-1:0] bank_open,
	output logic term_active,
	output logic [DCC_A_W-1:0] mode_word
);
	// Burst counter and latency line only serve these ranges
	if (!(BL == 4 || BL == 8) || MAX_AL < 1 || MAX_AL > 7 || MEM_AW < 4) begin : g_bad_param
		$error("dcc_mem: unsupported parameters");
	end

	dcc_pwr_e state_reg, state_next;
	logic cke_prev_reg;
	logic [DCC_BANKS-1:0] open_reg;
	logic [DCC_A_W-1:0] row_reg [DCC_BANKS];
	logic [DCC_A_W-1:0] mr_reg [DCC_BANKS];
	dcc_col_s pipe_reg [MAX_AL];
	dcc_col_s bst_reg;
	logic [3:0] bst_cnt_reg;
	logic [DCC_DW-1:0] mem [2**MEM_AW];
	logic [DCC_DW-1:0] rdata_reg;
	logic rvalid_reg;
	logic term_reg;

	function automatic logic [MEM_AW-1:0] mem_idx(input dcc_col_s c);
		mem_idx = MEM_AW'({c.ba, c.col});
	endfunction

	// Command decode at the rising edge
	wire [2:0] cmd = {link.ras_n, link.cas_n, link.we_n};
	wire sel = !link.cs_n;
	wire is_nop = !sel || cmd == DCC_CMD_NOP;
	wire steady = cke_prev_reg && link.cke;
	wire exe = steady && sel;
	wire fall = cke_prev_reg && !link.cke;
	wire rise = !cke_prev_reg && link.cke;
	wire all_idle = open_reg == '0;
	wire do_mrs = exe && cmd == DCC_CMD_MRS;
	wire do_act = exe && cmd == DCC_CMD_ACT;
	wire do_pre = exe && cmd == DCC_CMD_PRE;
	wire do_col = exe && (cmd == DCC_CMD_WR || cmd == DCC_CMD_RD);
	wire [DCC_AL_W-1:0] al_prog = mr_reg[DCC_MR_EXT1][DCC_AL_LSB +: DCC_AL_W];
	wire [DCC_AL_W-1:0] al = (al_prog > DCC_AL_W'(MAX_AL)) ? DCC_AL_W'(MAX_AL) : al_prog;
	wire odt_en = mr_reg[DCC_MR_EXT1][DCC_ODT_BIT_LO] || mr_reg[DCC_MR_EXT1][DCC_ODT_BIT_HI];
	dcc_col_s col_now;
	dcc_col_s fire;
	assign col_now = '{v: do_col, wr: cmd == DCC_CMD_WR, ap: link.addr[DCC_AP_BIT],
		ba: link.ba, col: link.addr[DCC_COL_W-1:0]};
	// Zero latency registers at once, else taken from the delay line
	assign fire = (al == '0) ? col_now : pipe_reg[al - 1'b1];
	wire beat = bst_cnt_reg != '0;
	wire last_beat = bst_cnt_reg == 4'h1;

	// Power state from the two enable samples
	always_comb begin
		state_next = state_reg;
		if (fall) begin
			if (sel && cmd == DCC_CMD_REF && all_idle)
				state_next = DCC_ST_SREF;
			else if (is_nop)
				state_next = all_idle ? DCC_ST_PPD : DCC_ST_APD;
		end else if (rise && is_nop) begin
			state_next = DCC_ST_ON;
		end
		// Low on both edges keeps the state whatever the bus shows
	end

	// Enable history and power state
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg <= DCC_ST_ON;
			cke_prev_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cke_prev_reg <= link.cke;
		end
	end

	// Additive-latency delay line, one stage per clock
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst)
			pipe_reg[0] <= '0;
		else
			pipe_reg[0] <= col_now;
	end
	for (genvar i = 1; i < MAX_AL; i++) begin : g_pipe
		always_ff @(posedge clk_sys or posedge sys_rst) begin
			if (sys_rst)
				pipe_reg[i] <= '0;
			else
				pipe_reg[i] <= pipe_reg[i-1];
		end
	end

	// Banks, rows and mode registers
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			open_reg <= '0;
			for (int b = 0; b < DCC_BANKS; b++) begin
				row_reg[b] <= '0;
				mr_reg[b] <= '0;
			end
		end else begin
			if (beat && last_beat && bst_reg.ap)
				open_reg[bst_reg.ba] <= 1'b0;
			if (do_act) begin
				open_reg[link.ba] <= 1'b1;
				row_reg[link.ba] <= link.addr;
			end
			if (do_pre) begin
				if (link.addr[DCC_AP_BIT])
					open_reg <= '0;
				else
					open_reg[link.ba] <= 1'b0;
			end
			if (do_mrs)
				mr_reg[link.ba] <= link.addr;
		end
	end

	// Burst sequencer; a new column command restarts it
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			bst_reg <= '0;
			bst_cnt_reg <= '0;
			rdata_reg <= '0;
			rvalid_reg <= 1'b0;
		end else begin
			rvalid_reg <= beat && !bst_reg.wr;
			if (beat && !bst_reg.wr)
				rdata_reg <= mem[mem_idx(bst_reg)];
			if (fire.v) begin
				bst_reg <= fire;
				bst_cnt_reg <= 4'(BL);
			end else if (beat) begin
				bst_cnt_reg <= bst_cnt_reg - 4'h1;
				bst_reg.col <= bst_reg.col + 1'b1;
			end
		end
	end

	// Write beats, one byte lane per mask bit
	always_ff @(posedge clk_sys) begin
		if (beat && bst_reg.wr) begin
			for (int k = 0; k < DCC_DM_W; k++) begin
				if (!link.dm[k])
					mem[mem_idx(bst_reg)][k*8 +: 8] <= link.wdata[k*8 +: 8];
			end
		end
	end

	// Termination follows its input when the extended mode register enables it, except in self refresh
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst)
			term_reg <= 1'b0;
		else
			term_reg <= link.odt && odt_en && state_next != DCC_ST_SREF;
	end

	assign link.rdata = rdata_reg;
	assign link.rvalid = rvalid_reg;
	assign pwr_state = state_reg;
	assign bank_open = open_reg;
	assign term_active = term_reg;
	assign mode_word = mr_reg[DCC_MR_MAIN];
endmodule // dcc_mem

// ===== rtl/dcc_ctl.sv
// Local design decisions: the strobed register port and the register offsets.
`timescale 1ns/100ps
// Controller end: register port in, paced command stream out
module dcc_ctl import dcc_pkg::*; #(
	parameter int BL = 4,
	parameter int AL = 0,
	parameter int T_MRD = 2,
	parameter int T_RP = 3,
	parameter int T_RFC = 20,
	parameter int T_XSNR = 30
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	dcc_if.ctl link,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata
);
	// Delays are parameters because they follow the speed grade
	if (!(BL == 4 || BL == 8) || AL < 0 || AL > 6 || T_MRD < 1 || T_RP < 1
		|| T_RFC < 1 || T_XSNR < 1 || T_XSNR > 255 || T_RFC > 255) begin : g_bad_param
		$error("dcc_ctl: unsupported parameters");
	end

	localparam logic [DCC_CNT_W-1:0] CNT_MRD = DCC_CNT_W'(T_MRD);
	localparam logic [DCC_CNT_W-1:0] CNT_RP = DCC_CNT_W'(T_RP);
	localparam logic [DCC_CNT_W-1:0] CNT_RFC = DCC_CNT_W'(T_RFC);
	localparam logic [DCC_CNT_W-1:0] CNT_COL = DCC_CNT_W'(AL + BL + 2);
	localparam logic [DCC_CNT_W-1:0] CNT_COL_AP = DCC_CNT_W'(AL + BL + 2 + T_RP);
	localparam logic [DCC_CNT_W-1:0] CNT_XSNR = DCC_CNT_W'(T_XSNR);
	localparam logic [DCC_CNT_W-1:0] CNT_XSRD = DCC_CNT_W'(DCC_XSRD_CLK);
	localparam logic [1:0] HOLD_MIN = 2'(DCC_CKE_MIN);

	// Software-facing registers
	logic pend_reg;
	logic [2:0] code_reg;
	logic [DCC_BA_W-1:0] pba_reg;
	logic [DCC_A_W-1:0] paddr_reg;
	logic ctl_cke_reg;
	logic ctl_odt_reg;
	logic [DCC_DW-1:0] wdata_reg;
	logic [DCC_DM_W-1:0] wmask_reg;
	logic [DCC_DW-1:0] rcap_reg;
	logic rcap_new_reg;
	logic err_reg;
	logic [31:0] rdata_reg;
	// Sequencing state
	logic sref_reg;
	logic pd_reg;
	logic [1:0] hold_reg;
	logic [DCC_CNT_W-1:0] busy_reg;
	logic [DCC_CNT_W-1:0] xsnr_reg;
	logic [DCC_CNT_W-1:0] xsrd_reg;
	logic [DCC_BANKS-1:0] open_reg;
	// Pin registers
	logic cke_reg;
	logic cs_n_reg;
	logic [2:0] cmd_reg;
	logic [DCC_BA_W-1:0] ba_reg;
	logic [DCC_A_W-1:0] addr_reg;
	logic odt_reg;

	function automatic logic is_col(input logic [2:0] c);
		is_col = c == DCC_CMD_RD || c == DCC_CMD_WR;
	endfunction

	// Register port decode
	wire wr_cmd = reg_wr && reg_addr == DCC_REG_CMD;
	wire wr_ctrl = reg_wr && reg_addr == DCC_REG_CTRL;
	wire wr_wdata = reg_wr && reg_addr == DCC_REG_WDATA;
	wire wr_stat = reg_wr && reg_addr == DCC_REG_STAT;
	wire rd_rdata = reg_rd && reg_addr == DCC_REG_RDATA;

	// Pacing conditions
	wire all_idle = open_reg == '0;
	wire hold_ok = hold_reg == HOLD_MIN;
	wire quiet = busy_reg == '0;
	wire pend_ref = pend_reg && code_reg == DCC_CMD_REF;
	wire read_ok = xsrd_reg == '0;
	wire bank_up = open_reg[pba_reg];
	// Only table commands in legal bank states are sent
	wire illegal = ((code_reg == DCC_CMD_MRS || code_reg == DCC_CMD_REF) && !all_idle)
		|| (code_reg == DCC_CMD_ACT && bank_up)
		|| (is_col(code_reg) && !bank_up)
		|| !(code_reg <= DCC_CMD_RD || code_reg == DCC_CMD_NOP);
	// Enable falls only on request and never mid-operation
	wire want_fall = cke_reg && !ctl_cke_reg && hold_ok && quiet && (!pend_reg || pend_ref);
	wire sref_go = want_fall && pend_ref && all_idle;
	wire pd_go = want_fall && !pend_reg;
	wire want_rise = !cke_reg && ctl_cke_reg && hold_ok;
	// A refresh queued just before an enable-drop write becomes self refresh entry
	wire drop_now = wr_ctrl && !reg_wdata[DCC_F_CKE];
	wire try_issue = cke_reg && ctl_cke_reg && pend_reg && quiet && xsnr_reg == '0
		&& !(pend_ref && drop_now)
		&& !(code_reg == DCC_CMD_RD && !read_ok);
	wire issue = try_issue && !illegal;
	wire refuse = (try_issue && illegal) || (want_fall && pend_ref && !all_idle);
	wire pd_any = pd_reg || sref_reg;
	wire [31:0] stat_word = 32'({pd_any, sref_reg, err_reg, read_ok, cke_reg, pend_reg});

	// Busy time for the command just sent
	logic [DCC_CNT_W-1:0] busy_load;
	always_comb begin
		unique case (code_reg)
			DCC_CMD_MRS: busy_load = CNT_MRD;
			DCC_CMD_PRE: busy_load = CNT_RP;
			DCC_CMD_REF: busy_load = CNT_RFC;
			DCC_CMD_RD, DCC_CMD_WR:
				busy_load = paddr_reg[DCC_AP_BIT] ? CNT_COL_AP : CNT_COL;
			default: busy_load = '0;
		endcase
	end

	// Command and control registers; a command write while one waits is dropped
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			pend_reg <= 1'b0;
			code_reg <= DCC_CMD_NOP;
			pba_reg <= '0;
			paddr_reg <= '0;
			ctl_cke_reg <= 1'b0;
			ctl_odt_reg <= 1'b0;
			wdata_reg <= '0;
			wmask_reg <= '0;
		end else begin
			if (issue || refuse)
				pend_reg <= 1'b0;
			else if (sref_go)
				pend_reg <= 1'b0;
			if (wr_cmd && !pend_reg) begin
				pend_reg <= 1'b1;
				code_reg <= reg_wdata[DCC_F_CODE +: 3];
				pba_reg <= reg_wdata[DCC_F_BA +: DCC_BA_W];
				paddr_reg <= reg_wdata[DCC_F_ADDR +: DCC_A_W];
			end
			if (wr_ctrl) begin
				ctl_cke_reg <= reg_wdata[DCC_F_CKE];
				ctl_odt_reg <= reg_wdata[DCC_F_ODT];
			end
			if (wr_wdata) begin
				wdata_reg <= reg_wdata[DCC_DW-1:0];
				wmask_reg <= reg_wdata[DCC_DW +: DCC_DM_W];
			end
		end
	end

	// Sticky flags: hardware set wins over software clear
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			err_reg <= 1'b0;
			rcap_reg <= '0;
			rcap_new_reg <= 1'b0;
		end else begin
			err_reg <= refuse || (err_reg && !(wr_stat && reg_wdata[DCC_F_ERR]));
			rcap_new_reg <= link.rvalid || (rcap_new_reg && !rd_rdata);
			if (link.rvalid)
				rcap_reg <= link.rdata;
		end
	end

	// Read data stands in the cycle after the strobe only
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst)
			rdata_reg <= '0;
		else if (reg_rd) begin
			unique case (reg_addr)
				DCC_REG_CMD: rdata_reg <= 32'({paddr_reg, 1'b0, pba_reg, 1'b0, code_reg});
				DCC_REG_CTRL: rdata_reg <= 32'({ctl_odt_reg, ctl_cke_reg});
				DCC_REG_WDATA: rdata_reg <= 32'({wmask_reg, wdata_reg});
				DCC_REG_STAT: rdata_reg <= stat_word;
				DCC_REG_RDATA: rdata_reg <= 32'({rcap_new_reg, rcap_reg});
				default: rdata_reg <= '0;
			endcase
		end else
			rdata_reg <= '0;
	end

	// Enable hold counter and power-mode tracking
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			hold_reg <= '0;
			sref_reg <= 1'b0;
			pd_reg <= 1'b0;
			xsnr_reg <= '0;
			xsrd_reg <= '0;
		end else begin
			if (sref_go || pd_go || want_rise)
				hold_reg <= '0;
			else if (!hold_ok)
				hold_reg <= hold_reg + 2'h1;
			if (sref_go)
				sref_reg <= 1'b1;
			if (pd_go)
				pd_reg <= 1'b1;
			if (want_rise) begin
				sref_reg <= 1'b0;
				pd_reg <= 1'b0;
			end
			// Self refresh exit opens the NOP and read-hold windows
			if (want_rise && sref_reg) begin
				xsnr_reg <= CNT_XSNR;
				xsrd_reg <= CNT_XSRD;
			end else begin
				if (xsnr_reg != '0)
					xsnr_reg <= xsnr_reg - 1'b1;
				if (xsrd_reg != '0)
					xsrd_reg <= xsrd_reg - 1'b1;
			end
		end
	end

	// Controller's view of open banks and operation time
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			open_reg <= '0;
			busy_reg <= '0;
		end else begin
			if (issue) begin
				busy_reg <= busy_load;
				if (code_reg == DCC_CMD_ACT)
					open_reg[pba_reg] <= 1'b1;
				else if (code_reg == DCC_CMD_PRE && paddr_reg[DCC_AP_BIT])
					open_reg <= '0;
				else if (code_reg == DCC_CMD_PRE || (is_col(code_reg) && paddr_reg[DCC_AP_BIT]))
					open_reg[pba_reg] <= 1'b0;
			end else if (sref_go)
				busy_reg <= CNT_RFC;
			else if (busy_reg != '0)
				busy_reg <= busy_reg - 1'b1;
		end
	end

	// Pin drive: NOP unless a command goes; transitions carry NOP, except REFRESH at self refresh entry
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			cke_reg <= 1'b0;
			cs_n_reg <= 1'b0;
			cmd_reg <= DCC_CMD_NOP;
			ba_reg <= '0;
			addr_reg <= '0;
			odt_reg <= 1'b0;
		end else begin
			cs_n_reg <= 1'b0;
			cmd_reg <= DCC_CMD_NOP;
			odt_reg <= ctl_odt_reg && !sref_reg;
			if (sref_go || pd_go)
				cke_reg <= 1'b0;
			else if (want_rise)
				cke_reg <= 1'b1;
			if (issue || sref_go) begin
				cmd_reg <= code_reg;
				ba_reg <= pba_reg;
				addr_reg <= paddr_reg;
			end
		end
	end

	assign link.cke = cke_reg;
	assign link.cs_n = cs_n_reg;
	assign link.ras_n = cmd_reg[2];
	assign link.cas_n = cmd_reg[1];
	assign link.we_n = cmd_reg[0];
	assign link.ba = ba_reg;
	assign link.addr = addr_reg;
	assign link.odt = odt_reg;
	assign link.dm = wmask_reg;
	assign link.wdata = wdata_reg;
	assign reg_rdata = rdata_reg;
endmodule // dcc_ctl

// ===== sim/dcc_monitor.sv
`timescale 1ns/100ps
// Watches the link between both ends and the memory end's state outputs
module dcc_monitor import dcc_pkg::*; (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic cke,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [DCC_BA_W-1:0] ba,
	input wire logic [DCC_A_W-1:0] addr,
	input wire logic rvalid,
	input wire logic [1:0] pwr_state,
	input wire logic [DCC_BANKS-1:0] bank_open,
	input wire logic term_active,
	input wire logic [DCC_A_W-1:0] mode_word
);
	// Strobe decode; only meaningful with chip select low
	wire logic [2:0] cmd_code = {ras_n, cas_n, we_n};
	wire logic cmd_nop = cs_n || (cmd_code == DCC_CMD_NOP);
	wire logic cmd_sel = !cs_n && cke;

	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	a_cke_hold_three: assert property ($changed(cke) |=> $stable(cke) [*2])
		else $error("clock enable changed again too soon");
	a_fall_cmd_legal: assert property ($fell(cke) |-> cmd_nop || cmd_code == DCC_CMD_REF)
		else $error("clock enable fell with a bad command");
	a_rise_cmd_nop: assert property ($rose(cke) |-> cmd_nop)
		else $error("clock enable rose without a no-operation");
	a_low_cke_quiet: assert property (!cke && !$past(cke) |-> cmd_nop)
		else $error("command shown while clock enable low");
	a_sref_entry: assert property ($fell(cke) && !cs_n && cmd_code == DCC_CMD_REF
		|-> ##[1:2] pwr_state == DCC_ST_SREF)
		else $error("self refresh not entered");
	a_sref_hold: assert property (pwr_state == DCC_ST_SREF && !cke
		|=> pwr_state == DCC_ST_SREF)
		else $error("self refresh left with enable low");
	a_pd_kind: assert property ($fell(cke) && cmd_nop && pwr_state == DCC_ST_ON
		|-> ##[1:2] pwr_state == ((|bank_open) ? DCC_ST_APD : DCC_ST_PPD))
		else $error("wrong power down kind");
	a_act_opens: assert property (cmd_sel && $past(cke) && cmd_code == DCC_CMD_ACT
		|=> bank_open[$past(ba)])
		else $error("activate did not open the bank");
	a_mrs_loads: assert property (cmd_sel && $past(cke) && cmd_code == DCC_CMD_MRS
		&& ba == DCC_MR_MAIN |=> mode_word == $past(addr))
		else $error("mode word not loaded");
	a_nop_keeps: assert property (!(cmd_sel && cmd_code == DCC_CMD_MRS)
		|=> $stable(mode_word))
		else $error("mode word changed without a load");
	a_sref_no_term: assert property (pwr_state == DCC_ST_SREF && $past(pwr_state) == DCC_ST_SREF
		|-> !term_active)
		else $error("termination active in self refresh");

	// Main scenarios reached
	c_sref: cover property (pwr_state == DCC_ST_SREF);
	c_apd: cover property (pwr_state == DCC_ST_APD);
	c_beat: cover property (rvalid);
endmodule // dcc_monitor

// ===== sim/dcc_tb.sv
`timescale 1ns/100ps
// Drives the controller's register port and watches the memory end
module dcc_tb import dcc_pkg::*; ();
	logic clk_sys;
	logic sys_rst;
	logic reg_wr;
	logic reg_rd;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata;
	logic [31:0] reg_rdata;
	logic [1:0] pwr_state;
	logic [DCC_BANKS-1:0] bank_open;
	logic term_active;
	logic [DCC_A_W-1:0] mode_word;
	logic [31:0] rd_val;
	localparam int TB_AL = 2;
	int lat;
	int num_errors = 0;
	int checked = 0;

	dcc_if link_if();
	dcc_ctl #(.AL(TB_AL)) i_dcc_ctl (.clk_sys(clk_sys), .sys_rst(sys_rst), .link(link_if),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
	dcc_mem i_dcc_mem (.clk_sys(clk_sys), .sys_rst(sys_rst), .link(link_if), .pwr_state(pwr_state),
		.bank_open(bank_open), .term_active(term_active), .mode_word(mode_word));
	dcc_monitor i_dcc_monitor (.clk_sys(clk_sys), .sys_rst(sys_rst), .cke(link_if.cke),
		.cs_n(link_if.cs_n), .ras_n(link_if.ras_n), .cas_n(link_if.cas_n), .we_n(link_if.we_n),
		.ba(link_if.ba), .addr(link_if.addr), .rvalid(link_if.rvalid), .pwr_state(pwr_state),
		.bank_open(bank_open), .term_active(term_active), .mode_word(mode_word));

	// 40 MHz system clock
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	// Single closing point for normal end and watchdog
	task give_verdict;
		begin
			$display("Comparisons %0d, mismatches %0d", checked, num_errors);
			if (num_errors == 0 && checked > 0) begin
				$display("No errors found");
			end else begin
				$display("Errors were found");
			end
			$finish;
		end
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		begin
			checked++;
			if (got !== exp) begin
				num_errors++;
				$display("BAD %0t got %h want %h", $time, got, exp);
			end
		end
	endtask

	// One write cycle, strobe dropped after one clock
	task regw(input logic [7:0] a, input logic [31:0] d);
		begin
			@(posedge clk_sys);
			reg_wr <= 1'b1;
			reg_addr <= a;
			reg_wdata <= d;
			@(posedge clk_sys);
			reg_wr <= 1'b0;
		end
	endtask

	// Two writes with no gap, so both land before the controller acts
	task regw2(input logic [7:0] a1, input logic [31:0] d1, input logic [7:0] a2,
		input logic [31:0] d2);
		begin
			@(posedge clk_sys);
			reg_wr <= 1'b1;
			reg_addr <= a1;
			reg_wdata <= d1;
			@(posedge clk_sys);
			reg_addr <= a2;
			reg_wdata <= d2;
			@(posedge clk_sys);
			reg_wr <= 1'b0;
		end
	endtask

	// Read data stands only in the cycle after the strobe
	task regr(input logic [7:0] a, output logic [31:0] d);
		begin
			@(posedge clk_sys);
			reg_rd <= 1'b1;
			reg_addr <= a;
			@(posedge clk_sys);
			reg_rd <= 1'b0;
			@(negedge clk_sys);
			d = reg_rdata;
		end
	endtask

	// Wait for the queued command to go out, then let its busy time run down
	task settle;
		logic [31:0] s;
		int n;
		begin
			n = 0;
			do begin
				regr(DCC_REG_STAT, s);
				n++;
			end while (s[0] !== 1'b0 && n < 100);
			if (n >= 100) begin
				chk(s & 32'h0000_0001, 32'h0000_0000);
			end
			repeat (40) @(posedge clk_sys);
		end
	endtask

	// Negedges from a read shown on the link to its first visible data beat
	task rd_lat(output int n);
		begin
			n = 0;
			do begin
				@(negedge clk_sys);
				n++;
			end while (!(link_if.cke && !link_if.cs_n && {link_if.ras_n, link_if.cas_n,
				link_if.we_n} == DCC_CMD_RD) && n < 100);
			n = 0;
			do begin
				@(negedge clk_sys);
				n++;
			end while (link_if.rvalid !== 1'b1 && n < 20);
		end
	endtask

	function automatic logic [31:0] mk_cmd(input logic [2:0] c, input logic [2:0] b,
		input logic [13:0] a);
		return {10'h000, a, 1'b0, b, 1'b0, c};
	endfunction

	task run(input logic [2:0] c, input logic [2:0] b, input logic [13:0] a);
		begin
			regw(DCC_REG_CMD, mk_cmd(c, b, a));
			settle;
		end
	endtask

	// Watchdog well beyond the expected run of just over a thousand cycles
	initial begin
		#500000;
		num_errors++;
		give_verdict;
	end

	initial begin
		sys_rst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0000_0000;
		repeat (3) @(posedge clk_sys);
		sys_rst <= 1'b0;
		regr(DCC_REG_RDATA, rd_val);
		chk(rd_val, 32'h0000_0000);
		regr(8'h14, rd_val);
		chk(rd_val, 32'h0000_0000);
		regw(DCC_REG_CTRL, 32'h0000_0001);
		settle;
		chk(32'(pwr_state), 32'(DCC_ST_ON));
		// Mode loads: main word, then termination enabled with an added latency of two
		run(DCC_CMD_MRS, DCC_MR_MAIN, 14'h0042);
		chk(32'(mode_word), 32'h0000_0042);
		run(DCC_CMD_MRS, DCC_MR_EXT1, 14'h0014);
		chk(32'(mode_word), 32'h0000_0042);
		regw(DCC_REG_CTRL, 32'h0000_0003);
		settle;
		chk(32'(term_active), 32'h0000_0001);
		run(DCC_CMD_ACT, 3'h1, 14'h0123);
		chk(32'(bank_open), 32'h0000_0002);
		// Second activate to an open bank is refused
		run(DCC_CMD_ACT, 3'h1, 14'h0040);
		regr(DCC_REG_STAT, rd_val);
		chk(rd_val & 32'h0000_0008, 32'h0000_0008);
		regw(DCC_REG_STAT, 32'h0000_0008);
		regr(DCC_REG_STAT, rd_val);
		chk(rd_val & 32'h0000_0008, 32'h0000_0000);
		// Full write, then a write with the low byte masked
		regw(DCC_REG_WDATA, 32'h0000_1234);
		run(DCC_CMD_WR, 3'h1, 14'h0004);
		regw(DCC_REG_WDATA, 32'h0001_ABCD);
		run(DCC_CMD_WR, 3'h1, 14'h0004);
		regw(DCC_REG_CMD, mk_cmd(DCC_CMD_RD, 3'h1, 14'h0004));
		rd_lat(lat);
		chk(32'(lat), 32'(TB_AL + 2));
		settle;
		regr(DCC_REG_RDATA, rd_val);
		chk(rd_val, 32'h0001_AB34);
		chk(32'(bank_open), 32'h0000_0002);
		run(DCC_CMD_RD, 3'h1, 14'h0404);
		chk(32'(bank_open), 32'h0000_0000);
		run(DCC_CMD_ACT, 3'h2, 14'h0011);
		run(DCC_CMD_WR, 3'h2, 14'h0408);
		chk(32'(bank_open), 32'h0000_0000);
		// Power down with a row open, then with all banks idle
		run(DCC_CMD_ACT, 3'h2, 14'h0011);
		regw(DCC_REG_CTRL, 32'h0000_0002);
		settle;
		chk(32'(pwr_state), 32'(DCC_ST_APD));
		chk(32'(term_active), 32'h0000_0001);
		regw(DCC_REG_CTRL, 32'h0000_0003);
		settle;
		chk(32'(pwr_state), 32'(DCC_ST_ON));
		run(DCC_CMD_PRE, 3'h0, 14'h0400);
		regw(DCC_REG_CTRL, 32'h0000_0002);
		settle;
		chk(32'(pwr_state), 32'(DCC_ST_PPD));
		regw(DCC_REG_CTRL, 32'h0000_0003);
		settle;
		// Self refresh entry, hold, exit and the read hold-off after it
		regw2(DCC_REG_CMD, mk_cmd(DCC_CMD_REF, 3'h0, 14'h0000), DCC_REG_CTRL, 32'h0000_0002);
		settle;
		chk(32'(pwr_state), 32'(DCC_ST_SREF));
		chk(32'(term_active), 32'h0000_0000);
		regr(DCC_REG_STAT, rd_val);
		chk(rd_val & 32'h0000_0010, 32'h0000_0010);
		regw(DCC_REG_CTRL, 32'h0000_0003);
		settle;
		chk(32'(pwr_state), 32'(DCC_ST_ON));
		regr(DCC_REG_STAT, rd_val);
		chk(rd_val & 32'h0000_0004, 32'h0000_0000);
		repeat (220) @(posedge clk_sys);
		regr(DCC_REG_STAT, rd_val);
		chk(rd_val & 32'h0000_0004, 32'h0000_0004);
		give_verdict;
	end
endmodule // dcc_tb
